// ===== inc/tsw_map.svh
// offsets, field positions, reset values and counts for the stopwatch sequencer
// assumes it is included by bare name from the design files
`ifndef TSW_MAP_SVH
`define TSW_MAP_SVH

// ==========================================================================
// register placement
`define TSW_START_FINE_RESULT_OFS 8'h10
`define TSW_RESULT_RESET 24'h000000
`define TSW_CYCLE_RESET 16'h0000

// ==========================================================================
// widths and counts
`define TSW_FINE_W 24
`define TSW_CYC_W 16
`define TSW_WRAP_PERIOD 63
`define TSW_MAX_STOPS 5
`define TSW_BYTE_SHIFT 8

`endif

// ===== inc/tsw_pkg.sv
// types shared by the stopwatch sequencer modules
// assumes nothing of its surroundings
package tsw_pkg;

  // ==========================================================================
  // sequencer states
  typedef enum logic [3:0] {
    TSW_IDLE = 4'h0,
    TSW_WAIT_START = 4'h1,
    TSW_FRAC_START = 4'h2,
    TSW_COUNT = 4'h3,
    TSW_FRAC_STOP = 4'h4,
    TSW_RUN_FIRST = 4'h5,
    TSW_CAL_SINGLE = 4'h6,
    TSW_CAL_SPAN = 4'h7
  } tsw_state_t;

  // ==========================================================================
  // measurement modes
  typedef enum logic {
    TSW_MODE_FIRST = 1'b0,
    TSW_MODE_SECOND = 1'b1
  } tsw_mode_t;

endpackage

// ===== design/tsw_ring_counter.sv
// fine tick counter with coarse wrap counter for the ring oscillator
// assumes ring_tick is a one-cycle pulse synchronous to clock
`timescale 1ns/1ns
`default_nettype none
`include "tsw_map.svh"

module tsw_ring_counter #(
  parameter int FINE_W = `TSW_FINE_W,
  parameter int CRS_W = `TSW_CYC_W,
  parameter int WRAP = `TSW_WRAP_PERIOD
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic run,
  input wire logic tick,
  // counts
  output logic [FINE_W-1:0] count_next,
  output logic [FINE_W-1:0] count,
  output logic [CRS_W-1:0] coarse
);

  localparam logic [5:0] WRAP_LAST = 6'(WRAP - 1);

  logic [FINE_W-1:0] cnt_run, cnt_d, cnt_q;
  logic [5:0] ph_run, ph_d, ph_q;
  logic [CRS_W-1:0] crs_run, crs_d, crs_q;

  // ==========================================================================
  // next values
  always_comb begin
    cnt_run = cnt_q;
    ph_run = ph_q;
    crs_run = crs_q;
    if (run && tick) begin
      cnt_run = cnt_q + 1'b1;
      if (ph_q == WRAP_LAST) begin
        ph_run = '0;
        crs_run = crs_q + 1'b1;
      end else begin
        ph_run = ph_q + 1'b1;
      end
    end
    // the tick of a closing window belongs to it, so a clear drops it instead of carrying it over
    cnt_d = clear ? '0 : cnt_run;
    ph_d = clear ? '0 : ph_run;
    crs_d = clear ? '0 : crs_run;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ph_q <= '0;
      crs_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      crs_q <= crs_d;
    end
  end

  assign count_next = cnt_run;
  assign count = cnt_q;
  assign coarse = crs_q;

endmodule // tsw_ring_counter

`default_nettype wire

// ===== design/tsw_stopwatch_sequencer.sv
// sequencer of a two-mode stopwatch: start, stops (masked in second mode only), overflows, calibration
// assumes start_edge, stop_edge and ring_tick are synchronous one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
`include "tsw_map.svh"

module tsw_stopwatch_sequencer #(
  parameter int FINE_W = `TSW_FINE_W,
  parameter int CYC_W = `TSW_CYC_W,
  parameter int MAX_STOPS = `TSW_MAX_STOPS
) (
  // clock and reset (reset is the enable pin)
  input wire logic clock,
  input wire logic rst_n,
  // configuration
  input wire logic start_meas,
  input wire logic meas_mode,
  input wire logic [2:0] stop_count_sel,
  input wire logic [7:0] cal_span_setting,
  input wire logic [7:0] stop_mask_high_byte,
  input wire logic [7:0] stop_mask_low_byte,
  input wire logic [7:0] ref_cycle_limit_high_byte,
  input wire logic [7:0] ref_cycle_limit_low_byte,
  input wire logic [7:0] wrap_limit_high_byte,
  input wire logic [7:0] wrap_limit_low_byte,
  // front end
  input wire logic start_edge,
  input wire logic stop_edge,
  input wire logic ring_tick,
  output logic ring_run,
  // status
  output logic busy,
  output logic meas_done_flag,
  output logic wrap_limit_flag,
  output logic ref_cycle_limit_flag,
  // results
  output logic [FINE_W-1:0] start_fine_result,
  output logic [FINE_W-1:0] fine_result_stop_a,
  output logic [FINE_W-1:0] fine_result_stop_b,
  output logic [FINE_W-1:0] fine_result_stop_c,
  output logic [FINE_W-1:0] fine_result_stop_d,
  output logic [FINE_W-1:0] fine_result_stop_e,
  output logic [CYC_W-1:0] cycle_result_stop_a,
  output logic [CYC_W-1:0] cycle_result_stop_b,
  output logic [CYC_W-1:0] cycle_result_stop_c,
  output logic [CYC_W-1:0] cycle_result_stop_d,
  output logic [CYC_W-1:0] cycle_result_stop_e,
  output logic [FINE_W-1:0] cal_single_period_count,
  output logic [FINE_W-1:0] cal_multi_period_count
);

  // ==========================================================================
  // helpers
  function automatic logic [15:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
    join_bytes = {hi, lo}; // hi x 256 + lo
  endfunction

  function automatic logic is_ring_state(input tsw_pkg::tsw_state_t s);
    is_ring_state = (s == tsw_pkg::TSW_FRAC_START) || (s == tsw_pkg::TSW_FRAC_STOP) ||
                    (s == tsw_pkg::TSW_RUN_FIRST) || (s == tsw_pkg::TSW_CAL_SINGLE) ||
                    (s == tsw_pkg::TSW_CAL_SPAN);
  endfunction

  logic [15:0] mask_thr, cyc_limit, wrap_limit;
  logic [2:0] last_idx;
  logic [7:0] span_eff;

  assign mask_thr = join_bytes(stop_mask_high_byte, stop_mask_low_byte);
  assign cyc_limit = join_bytes(ref_cycle_limit_high_byte, ref_cycle_limit_low_byte);
  assign wrap_limit = join_bytes(wrap_limit_high_byte, wrap_limit_low_byte);
  // out-of-range stop counts fall back to the maximum
  assign last_idx = (stop_count_sel > 3'(MAX_STOPS - 1)) ? 3'(MAX_STOPS - 1) : stop_count_sel;
  // a zero span would leave the span window empty, so it runs one period
  assign span_eff = (cal_span_setting == 8'h00) ? 8'h01 : cal_span_setting;

  // ==========================================================================
  // state
  tsw_pkg::tsw_state_t state_d, state_q;
  logic [2:0] idx_d, idx_q;
  logic [CYC_W:0] cyc_d, cyc_q;
  logic [7:0] span_d, span_q;
  logic done_d, done_q, wflag_d, wflag_q, cflag_d, cflag_q;
  logic [FINE_W-1:0] fine_d [0:MAX_STOPS];
  logic [FINE_W-1:0] fine_q [0:MAX_STOPS];
  logic [CYC_W-1:0] cres_d [0:MAX_STOPS-1];
  logic [CYC_W-1:0] cres_q [0:MAX_STOPS-1];
  logic [FINE_W-1:0] cal1_d, cal1_q, cal2_d, cal2_q;

  logic ring_clear;
  logic [FINE_W-1:0] fine_now;
  logic [15:0] coarse_now;
  logic wrap_hit, cyc_hit, stop_ok;

  assign ring_run = is_ring_state(state_q);
  // a fresh window starts from zero each time the sequencer enters a ring state, even from another ring state
  assign ring_clear = (state_d != state_q) && is_ring_state(state_d);

  tsw_ring_counter #(
    .FINE_W(FINE_W),
    .CRS_W(16),
    .WRAP(`TSW_WRAP_PERIOD)
  ) u_ring (
    .clock(clock),
    .rst_n(rst_n),
    .clear(ring_clear),
    .run(ring_run),
    .tick(ring_tick),
    .count_next(fine_now),
    .count(),
    .coarse(coarse_now)
  );

  assign wrap_hit = ring_run && (coarse_now >= wrap_limit);
  assign cyc_hit = (cyc_q > {1'b0, cyc_limit});
  assign stop_ok = stop_edge && (cyc_q >= {1'b0, mask_thr});

  // ==========================================================================
  // next-state logic
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    cyc_d = cyc_q;
    span_d = span_q;
    done_d = done_q;
    wflag_d = wflag_q;
    cflag_d = cflag_q;
    fine_d = fine_q;
    cres_d = cres_q;
    cal1_d = cal1_q;
    cal2_d = cal2_q;
    case (state_q)
      tsw_pkg::TSW_IDLE: begin
        if (start_meas) begin
          // results stay until the next start clears them
          for (int i = 0; i <= MAX_STOPS; i++) begin
            fine_d[i] = `TSW_RESULT_RESET;
          end
          for (int i = 0; i < MAX_STOPS; i++) begin
            cres_d[i] = `TSW_CYCLE_RESET;
          end
          cal1_d = `TSW_RESULT_RESET;
          cal2_d = `TSW_RESULT_RESET;
          done_d = 1'b0;
          wflag_d = 1'b0;
          cflag_d = 1'b0;
          idx_d = '0;
          cyc_d = '0;
          state_d = tsw_pkg::TSW_WAIT_START;
        end
      end
      tsw_pkg::TSW_WAIT_START: begin
        // no timeout while waiting
        if (start_edge) begin
          state_d = (meas_mode == tsw_pkg::TSW_MODE_SECOND) ? tsw_pkg::TSW_FRAC_START
                                                           : tsw_pkg::TSW_RUN_FIRST;
        end
      end
      tsw_pkg::TSW_RUN_FIRST: begin
        // cycle counter stays idle in this mode
        if (stop_edge) begin
          fine_d[idx_q] = fine_now;
          idx_d = idx_q + 3'h1;
          if (idx_q == last_idx) begin
            state_d = tsw_pkg::TSW_CAL_SINGLE;
          end
        end else if (wrap_hit) begin
          wflag_d = 1'b1;
          done_d = 1'b1;
          state_d = tsw_pkg::TSW_IDLE;
        end
      end
      tsw_pkg::TSW_FRAC_START: begin
        fine_d[0] = fine_now;
        cyc_d = '0;
        state_d = tsw_pkg::TSW_COUNT;
      end
      tsw_pkg::TSW_COUNT: begin
        cyc_d = cyc_q + 1'b1;
        if (cyc_hit) begin
          cflag_d = 1'b1;
          done_d = 1'b1;
          state_d = tsw_pkg::TSW_IDLE;
        end else if (stop_ok) begin
          cres_d[idx_q] = cyc_q[CYC_W-1:0];
          state_d = tsw_pkg::TSW_FRAC_STOP;
        end
      end
      tsw_pkg::TSW_FRAC_STOP: begin
        cyc_d = cyc_q + 1'b1;
        fine_d[idx_q + 3'h1] = fine_now;
        idx_d = idx_q + 3'h1;
        state_d = (idx_q == last_idx) ? tsw_pkg::TSW_CAL_SINGLE : tsw_pkg::TSW_COUNT;
      end
      tsw_pkg::TSW_CAL_SINGLE: begin
        cal1_d = fine_now;
        span_d = span_eff;
        state_d = tsw_pkg::TSW_CAL_SPAN;
      end
      tsw_pkg::TSW_CAL_SPAN: begin
        span_d = span_q - 8'h01;
        if (span_q <= 8'h01) begin
          cal2_d = fine_now;
          done_d = 1'b1;
          state_d = tsw_pkg::TSW_IDLE;
        end
      end
      default: begin
        state_d = tsw_pkg::TSW_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // registers; enable low is the synchronous reset of everything
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= tsw_pkg::TSW_IDLE;
      idx_q <= 3'h0;
      cyc_q <= '0;
      span_q <= 8'h00;
      done_q <= 1'b0;
      wflag_q <= 1'b0;
      cflag_q <= 1'b0;
      for (int i = 0; i <= MAX_STOPS; i++) begin
        fine_q[i] <= `TSW_RESULT_RESET;
      end
      for (int i = 0; i < MAX_STOPS; i++) begin
        cres_q[i] <= `TSW_CYCLE_RESET;
      end
      cal1_q <= `TSW_RESULT_RESET;
      cal2_q <= `TSW_RESULT_RESET;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      cyc_q <= cyc_d;
      span_q <= span_d;
      done_q <= done_d;
      wflag_q <= wflag_d;
      cflag_q <= cflag_d;
      fine_q <= fine_d;
      cres_q <= cres_d;
      cal1_q <= cal1_d;
      cal2_q <= cal2_d;
    end
  end

  // ==========================================================================
  // outputs
  assign busy = (state_q != tsw_pkg::TSW_IDLE);
  assign meas_done_flag = done_q;
  assign wrap_limit_flag = wflag_q;
  assign ref_cycle_limit_flag = cflag_q;
  assign start_fine_result = fine_q[0];
  assign fine_result_stop_a = fine_q[1];
  assign fine_result_stop_b = fine_q[2];
  assign fine_result_stop_c = fine_q[3];
  assign fine_result_stop_d = fine_q[4];
  assign fine_result_stop_e = fine_q[5];
  assign cycle_result_stop_a = cres_q[0];
  assign cycle_result_stop_b = cres_q[1];
  assign cycle_result_stop_c = cres_q[2];
  assign cycle_result_stop_d = cres_q[3];
  assign cycle_result_stop_e = cres_q[4];
  assign cal_single_period_count = cal1_q;
  assign cal_multi_period_count = cal2_q;

endmodule // tsw_stopwatch_sequencer

`default_nettype wire

// ===== bench/tsw_stopwatch_sequencer_props.sv
// port assertions for the stopwatch sequencer
// assumes it is bound into the sequencer and sees only its ports
`timescale 1ns/1ns
`default_nettype none

module tsw_stopwatch_sequencer_props #(
  parameter int FINE_W = 24,
  parameter int CYC_W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // inputs
  input wire logic start_meas,
  input wire logic meas_mode,
  input wire logic start_edge,
  // outputs
  input wire logic ring_run,
  input wire logic busy,
  input wire logic meas_done_flag,
  input wire logic wrap_limit_flag,
  input wire logic ref_cycle_limit_flag,
  input wire logic [FINE_W-1:0] start_fine_result,
  input wire logic [CYC_W-1:0] cycle_result_stop_a,
  input wire logic [FINE_W-1:0] cal_single_period_count
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // reset, arm and start
  sequence s_arm;
    !busy && start_meas;
  endsequence
  sequence s_go;
    s_arm ##1 start_edge;
  endsequence

  chk_arm_clear: assert property (s_arm |=> busy && !meas_done_flag && !ref_cycle_limit_flag)
    else $error("arm left old status");
  chk_reset_clear: assert property ($rose(rst_n) |-> !busy && !ring_run && !meas_done_flag
    && !wrap_limit_flag && cycle_result_stop_a == 16'h0000 && start_fine_result == 24'h000000)
    else $error("reset left state behind");
  chk_wait_start: assert property (s_arm ##1 (!start_edge)[*8] |-> busy && !meas_done_flag)
    else $error("gave up waiting for start");
  chk_start_ring: assert property (s_go |=> ring_run)
    else $error("ring idle after start");
  chk_frac_one: assert property (s_go ##0 meas_mode |=> ring_run ##1 !ring_run)
    else $error("start fraction not one clock");
  chk_first_runs: assert property (s_go ##0 !meas_mode |=> ring_run[*2])
    else $error("ring stopped in first mode");

  // ==========================================================================
  // completion
  chk_done_idle: assert property ($rose(meas_done_flag) |-> !busy)
    else $error("done while busy");
  chk_cal_first: assert property (
    $rose(meas_done_flag) && !wrap_limit_flag && !ref_cycle_limit_flag |-> $past(ring_run))
    else $error("done without calibration");
  chk_ovf_ends: assert property (
    $rose(wrap_limit_flag || ref_cycle_limit_flag) |-> meas_done_flag && !busy
    && cal_single_period_count == 24'h000000)
    else $error("overflow did not end run");
  chk_result_hold: assert property (
    rst_n && meas_done_flag && !busy && !start_meas |=> meas_done_flag && $stable(start_fine_result)
    && $stable(cycle_result_stop_a))
    else $error("results changed after done");
endmodule // tsw_stopwatch_sequencer_props

bind tsw_stopwatch_sequencer tsw_stopwatch_sequencer_props #(.FINE_W(FINE_W), .CYC_W(CYC_W)) u_props (
  .clock(clock), .rst_n(rst_n), .start_meas(start_meas), .meas_mode(meas_mode), .start_edge(start_edge),
  .ring_run(ring_run), .busy(busy), .meas_done_flag(meas_done_flag), .wrap_limit_flag(wrap_limit_flag),
  .ref_cycle_limit_flag(ref_cycle_limit_flag), .start_fine_result(start_fine_result),
  .cycle_result_stop_a(cycle_result_stop_a), .cal_single_period_count(cal_single_period_count)
);

`default_nettype wire

// ===== bench/tsw_front_end.sv
// pulse source model: start and stop events and the ring oscillator
// assumes the caller sits on a rising clock edge when it calls a task
`timescale 1ns/1ns
`default_nettype none

module tsw_front_end (
  // clock
  input wire logic clock,
  // ring enable from the sequencer
  input wire logic ring_run,
  // events
  output logic start_edge,
  output logic stop_edge,
  output logic ring_tick
);
  // the ring only oscillates while enabled, one tick per clock
  assign ring_tick = ring_run;

  initial begin
    start_edge = 1'b0;
    stop_edge = 1'b0;
  end

  task automatic fire_start();
    start_edge <= 1'b1;
    @(posedge clock);
    start_edge <= 1'b0;
  endtask

  // gap sets how slowly the echo follows the last event
  task automatic fire_stop(input int gap);
    repeat (gap) @(posedge clock);
    stop_edge <= 1'b1;
    @(posedge clock);
    stop_edge <= 1'b0;
  endtask
endmodule // tsw_front_end

`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the stopwatch sequencer
// assumes the front-end model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clock, rst_n, start_meas, meas_mode, start_edge, stop_edge, ring_tick, ring_run, busy, done, wfl, cfl;
  logic [2:0] nst;
  logic [7:0] span, mh, ml, lh, ll, wh, wl;
  logic [23:0] f0, fa, fb, fc, fd, fe, cal1, cal2;
  logic [15:0] ca, cb, cc, cd, ce;
  int miscompares, checks, n;

  // ==========================================================================
  // clock, design and front end
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  tsw_stopwatch_sequencer u_tsw_stopwatch_sequencer (
    .clock(clock), .rst_n(rst_n), .start_meas(start_meas), .meas_mode(meas_mode), .stop_count_sel(nst),
    .cal_span_setting(span), .stop_mask_high_byte(mh), .stop_mask_low_byte(ml),
    .ref_cycle_limit_high_byte(lh), .ref_cycle_limit_low_byte(ll), .wrap_limit_high_byte(wh),
    .wrap_limit_low_byte(wl), .start_edge(start_edge), .stop_edge(stop_edge), .ring_tick(ring_tick),
    .ring_run(ring_run), .busy(busy), .meas_done_flag(done), .wrap_limit_flag(wfl), .ref_cycle_limit_flag(cfl),
    .start_fine_result(f0), .fine_result_stop_a(fa), .fine_result_stop_b(fb), .fine_result_stop_c(fc),
    .fine_result_stop_d(fd), .fine_result_stop_e(fe), .cycle_result_stop_a(ca), .cycle_result_stop_b(cb),
    .cycle_result_stop_c(cc), .cycle_result_stop_d(cd), .cycle_result_stop_e(ce),
    .cal_single_period_count(cal1), .cal_multi_period_count(cal2)
  );

  tsw_front_end u_tsw_front_end (
    .clock(clock), .ring_run(ring_run), .start_edge(start_edge), .stop_edge(stop_edge), .ring_tick(ring_tick)
  );

  // ==========================================================================
  // helpers
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [159:0] got, input logic [159:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cfg(input logic m, input logic [2:0] k, input logic [7:0] s, input logic [15:0] mk, lim, wr);
    meas_mode <= m;
    nst <= k;
    span <= s;
    {mh, ml} <= mk;
    {lh, ll} <= lim;
    {wh, wl} <= wr;
  endtask

  task automatic arm();
    @(posedge clock);
    start_meas <= 1'b1;
    @(posedge clock);
    start_meas <= 1'b0;
  endtask

  // bounded: a hung sequencer ends the run here
  task automatic wait_done();
    n = 0;
    while (!(done === 1'b1 && busy === 1'b0)) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 400) begin
        miscompares++;
        $display("[FAIL] %0t no completion", $time);
        final_report();
      end
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_second();
    cfg(1'b1, 3'h7, 8'h04, 16'h0003, 16'h0100, 16'hFFFF); // 7 clamps to five stops
    arm();
    repeat (20) @(posedge clock);
    #1;
    cmp({busy, done}, 2'b10, "waiting");
    u_tsw_front_end.fire_start();
    u_tsw_front_end.fire_stop(2); // count 1, inside the mask
    u_tsw_front_end.fire_stop(3);
    u_tsw_front_end.fire_stop(1);
    u_tsw_front_end.fire_stop(2);
    u_tsw_front_end.fire_stop(1);
    u_tsw_front_end.fire_stop(4);
    wait_done();
    cmp({ca, cb, cc, cd, ce}, {16'h0005, 16'h0007, 16'h000A, 16'h000C, 16'h0011}, "cycles");
    cmp({f0, fa, fb, fc, fd, fe}, {6{24'h000001}}, "fine");
    cmp({cal1, cal2}, {24'h000001, 24'h000004}, "cal");
    cmp((cal2 - cal1) / (span - 8'h01), 24'h000001, "lsb");
    repeat (5) @(posedge clock);
    #1;
    cmp({ca, fe, done}, {16'h0005, 24'h000001, 1'b1}, "hold");
    $display("test second mode done");
  endtask

  task automatic t_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    cmp({busy, done, ca, fe, cal2}, 160'h0, "glitch");
    $display("test reset done");
  endtask

  task automatic t_first();
    cfg(1'b0, 3'h1, 8'h00, 16'h0000, 16'h0000, 16'hFFFF);
    arm();
    u_tsw_front_end.fire_start();
    u_tsw_front_end.fire_stop(2);
    u_tsw_front_end.fire_stop(4);
    wait_done();
    cmp({f0, fa, ca, cfl}, {24'h000003, 24'h000008, 16'h0000, 1'b0}, "first");
    cmp({cal1, cal2}, {24'h000001, 24'h000001}, "cal");
    $display("test first mode done");
  endtask

  task automatic t_limit();
    cfg(1'b1, 3'h2, 8'h02, 16'h0108, 16'h0102, 16'hFFFF);
    arm();
    u_tsw_front_end.fire_start();
    u_tsw_front_end.fire_stop(2);
    wait_done();
    cmp({cfl, wfl, cal1, ca}, {2'b10, 40'h0}, "limit");
    $display("test cycle limit done");
  endtask

  task automatic t_wrap();
    cfg(1'b0, 3'h0, 8'h01, 16'h0000, 16'h0000, 16'h0001);
    arm();
    u_tsw_front_end.fire_start();
    wait_done();
    cmp({wfl, cfl, cal1}, {2'b10, 24'h000000}, "wrap");
    cmp(n > 61 && n < 67, 1'b1, "wrap time");
    $display("test wrap limit done");
  endtask

  initial begin
    miscompares = 0;
    checks = 0;
    rst_n = 1'b0; // first of two rising transitions after power-up
    start_meas = 1'b0;
    cfg(1'b0, 3'h0, 8'h01, 16'h0000, 16'h0000, 16'hFFFF);
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    cmp({busy, done, f0, ca}, 160'h0, "reset");
    t_second();
    t_reset();
    t_first();
    t_limit();
    t_wrap();
    final_report();
  end
endmodule // tb

`default_nettype wire
